// >>> rtl/aicbi_pkg.sv
// Package of constants and carrier types for the bus cycle interlock block
package aicbi_pkg;
  localparam int ACK_CLOCKS_PLAIN  = 4;
  localparam int ACK_CLOCKS_REMOTE = 8;
  localparam int BUS_BACKOFF_N_WIN_FIRST    = 1;
  localparam int BUS_BACKOFF_N_WIN_LAST     = 3;
  localparam int SERIAL_TOGGLES    = 20;
  localparam int SYNC_STAGES       = 2;
  localparam int UNIT_ID_WIDTH     = 4;
  localparam logic [3:0] ID_RESET_VALUE = 4'h0;
  localparam int CNT_WIDTH         = 5;

  typedef enum logic [2:0] {
    AICBI_IDLE,
    AICBI_ACK2,
    AICBI_REGRD,
    AICBI_HUNG
  } aicbi_state_t;

  // Bus pins after synchronisation, all active high
  typedef struct packed {
    logic backoff;
    logic hold;
    logic addr_strobe;
    logic burst_ready;
    logic soft_init;
    logic mgmt_int;
    logic serial_clk;
  } aicbi_bus_t;

  // Requests from the core side
  typedef struct packed {
    logic       ack2_start;
    logic       regrd_start;
    logic       reg_write;
    logic       pipelined;
    logic       remote_read;
    logic       msg_init;
    logic       msg_smi;
    logic       id_write;
    logic [3:0] id_value;
  } aicbi_req_t;
endpackage

// >>> rtl/aicbi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module aicbi_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } aicbi_sync_state_t;

  aicbi_sync_state_t state;
  aicbi_sync_state_t next_state;

  initial begin
    if (WIDTH < 1) $error("aicbi_sync: WIDTH must be positive");
  end

  always_comb begin
    next_state    = state;
    next_state.s1 = async_in;
    next_state.s2 = state.s1;
  end

  // Reset value is a constant at every instance
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.s2 ^ reset_value_in;
endmodule

// >>> rtl/aicbi_top.sv
// Local interrupt unit bus cycle interlocks
`timescale 1ns/1ps
module aicbi_top (
  input  wire logic                clock_in,
  input  wire logic                reset_n_in,
  input  wire logic                bus_backoff_n_in,
  input  wire logic                bus_hold_in,
  input  wire logic                address_strobe_n_in,
  input  wire logic                burst_ready_n_in,
  input  wire logic                soft_init_in,
  input  wire logic                system_mgmt_interrupt_n_in,
  input  wire logic                interrupt_serial_clock_in,
  input  wire logic [3:0]          byte_enables_n_in,
  input  wire logic                redundancy_master_checker_n_in,
  input  wire logic                redundancy_lockstep_in,
  input  wire aicbi_pkg::aicbi_req_t req_in,
  output logic                     ack2_done_out,
  output logic                     regrd_done_out,
  output logic                     hung_out,
  output logic                     single_read_out,
  output logic                     bus_desync_out,
  output logic                     bus_cycle_out,
  output logic                     internal_error_n_out,
  output logic                     soft_init_event_out,
  output logic                     mgmt_event_out,
  output logic [3:0]               unit_id_out,
  output logic                     outputs_tristate_out,
  output logic                     interrupt_unit_enable_out
);
  localparam int SW = 7;

  typedef struct packed {
    aicbi_pkg::aicbi_state_t                fsm;
    logic [aicbi_pkg::CNT_WIDTH-1:0]        clk_cnt;
    logic                                   bus_backoff_n_seen;
    logic                                   bus_backoff_n_prev;
    logic                                   hold_prev;
    logic                                   bus_backoff_n_1clk;
    logic                                   stray_ready;
    logic                                   single_read;
    logic [1:0]                             leftover;
    logic                                   desync;
    logic                                   ack2_done;
    logic                                   regrd_done;
    logic                                   bus_cycle;
    logic                                   err_pend;
    logic                                   internal_error_n_n;
    logic                                   init_prev;
    logic                                   smi_prev;
    logic                                   init_ev;
    logic                                   smi_ev;
    logic                                   in_reset;
    logic                                   unit_en;
    logic [aicbi_pkg::UNIT_ID_WIDTH-1:0]    unit_id;
    logic                                   tristate;
  } aicbi_top_state_t;

  aicbi_top_state_t  state;
  aicbi_top_state_t  next_state;
  aicbi_pkg::aicbi_bus_t bus;
  logic [SW-1:0]     raw;
  logic [SW-1:0]     synced;
  logic [3:0]        be_sync;
  logic              frc_sync;
  logic              rst_sync;
  logic [1:0]        free_sync;
  logic              pclk_free_prev;
  logic [aicbi_pkg::CNT_WIDTH-1:0] toggles_free;

  // Active-low pins inverted before sync so all stages are active high
  assign raw = {~bus_backoff_n_in, bus_hold_in, ~address_strobe_n_in,
                ~burst_ready_n_in, soft_init_in,
                ~system_mgmt_interrupt_n_in, interrupt_serial_clock_in};

  aicbi_sync #(.WIDTH(SW)) u_sync_bus (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .async_in       (raw),
    .reset_value_in ('0),
    .sync_out       (synced)
  );

  // Straps and their own reset-release marker
  aicbi_sync #(.WIDTH(6)) u_sync_strap (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    // Identifier is the pin level; pulldowns give the 0000 default
    .async_in       ({byte_enables_n_in, ~redundancy_master_checker_n_in,
                      1'b1}),
    .reset_value_in ('0),
    .sync_out       ({be_sync, frc_sync, rst_sync})
  );

  // Unreset: must watch the serial clock while reset holds all else
  aicbi_sync #(.WIDTH(2)) u_sync_free (
    .clock_in       (clock_in),
    .reset_n_in     (1'b1),
    .async_in       ({interrupt_serial_clock_in, reset_n_in}),
    .reset_value_in ('0),
    .sync_out       (free_sync)
  );

  // Cleared once release is seen; unknown until the first release
  always_ff @(posedge clock_in) begin
    pclk_free_prev <= free_sync[1];
    if (free_sync[0]) begin
      toggles_free <= '0;
    end else if (free_sync[1] != pclk_free_prev && toggles_free != '1) begin
      toggles_free <= toggles_free + 1'b1;
    end
  end

  assign bus = synced;

  always_comb begin
    logic active;
    logic [aicbi_pkg::CNT_WIDTH-1:0] limit;
    active = 1'b0;
    limit  = '0;
    next_state            = state;
    next_state.bus_backoff_n_prev  = bus.backoff;
    next_state.hold_prev  = bus.hold;
    next_state.ack2_done  = 1'b0;
    next_state.regrd_done = 1'b0;
    next_state.init_ev    = 1'b0;
    next_state.smi_ev     = 1'b0;
    next_state.internal_error_n_n     = 1'b1;
    next_state.init_prev  = bus.soft_init;
    next_state.smi_prev   = bus.mgmt_int;
    next_state.bus_cycle  = 1'b0;

    // Straps latched once rst_sync is seen, on the third clock after release
    if (state.in_reset && rst_sync) begin
      next_state.in_reset = 1'b0;
      next_state.unit_id  = be_sync;
      next_state.tristate = frc_sync;
      next_state.unit_en  = (toggles_free >=
        aicbi_pkg::CNT_WIDTH'(aicbi_pkg::SERIAL_TOGGLES));
    end
    if (!state.in_reset && req_in.id_write) begin
      next_state.unit_id = req_in.id_value;
    end

    // Edge detection; serial messages refused while pin still held
    if (bus.soft_init && !state.init_prev) next_state.init_ev = 1'b1;
    if (bus.mgmt_int && !state.smi_prev) next_state.smi_ev = 1'b1;
    if (req_in.msg_init && !bus.soft_init) next_state.init_ev = 1'b1;
    if (req_in.msg_smi && !bus.mgmt_int) next_state.smi_ev = 1'b1;

    // Register writes complete internally, no bus cycle
    if (req_in.reg_write && !req_in.pipelined)
      next_state.bus_cycle = 1'b0;
    if (req_in.reg_write && req_in.pipelined && redundancy_lockstep_in &&
        !state.tristate)
      next_state.err_pend = 1'b1;
    if (state.err_pend && bus.burst_ready) begin
      next_state.err_pend = 1'b0;
      next_state.internal_error_n_n   = 1'b0;
    end

    // Leftover burst readies after a restarted linefill
    if (state.single_read && bus.burst_ready) begin
      next_state.single_read = 1'b0;
      next_state.leftover    = 2'h3;
    end else if (state.leftover != 2'h0 && bus.burst_ready) begin
      next_state.leftover = state.leftover - 2'h1;
      if (bus.addr_strobe || state.bus_cycle)
        next_state.desync = 1'b1;
    end
    if (req_in.pipelined && state.bus_backoff_n_prev && !bus.backoff &&
        state.bus_backoff_n_1clk && state.fsm == aicbi_pkg::AICBI_REGRD)
      next_state.single_read = 1'b1;
    if (bus.addr_strobe) next_state.bus_cycle = 1'b1;

    active = state.fsm == aicbi_pkg::AICBI_ACK2 ||
             state.fsm == aicbi_pkg::AICBI_REGRD;
    limit = req_in.remote_read ?
      aicbi_pkg::CNT_WIDTH'(aicbi_pkg::ACK_CLOCKS_REMOTE) :
      aicbi_pkg::CNT_WIDTH'(aicbi_pkg::ACK_CLOCKS_PLAIN);
    // Backoff just raised without hold; one clock old when it is read
    next_state.bus_backoff_n_1clk = active && bus.backoff && !state.bus_backoff_n_prev &&
                           !bus.hold;

    case (state.fsm)
      aicbi_pkg::AICBI_IDLE: begin
        next_state.clk_cnt     = '0;
        next_state.bus_backoff_n_seen   = 1'b0;
        next_state.stray_ready = bus.addr_strobe && bus.burst_ready;
        // Only an idle bus lets an internal cycle begin
        // Done pulse still up: the request has not been dropped yet
        if (!bus.addr_strobe && !state.bus_cycle && state.unit_en &&
            !state.ack2_done && !state.regrd_done) begin
          if (req_in.ack2_start)
            next_state.fsm = aicbi_pkg::AICBI_ACK2;
          else if (req_in.regrd_start)
            next_state.fsm = aicbi_pkg::AICBI_REGRD;
        end
      end
      aicbi_pkg::AICBI_ACK2, aicbi_pkg::AICBI_REGRD: begin
        next_state.clk_cnt = state.clk_cnt + 1'b1;
        if (bus.backoff &&
            state.clk_cnt + 1'b1 >=
              aicbi_pkg::CNT_WIDTH'(aicbi_pkg::BUS_BACKOFF_N_WIN_FIRST) &&
            state.clk_cnt + 1'b1 <=
              aicbi_pkg::CNT_WIDTH'(aicbi_pkg::BUS_BACKOFF_N_WIN_LAST))
          next_state.bus_backoff_n_seen = 1'b1;
        if (state.fsm == aicbi_pkg::AICBI_ACK2 && state.bus_backoff_n_seen &&
            !bus.backoff && state.clk_cnt + 1'b1 < limit)
          next_state.fsm = aicbi_pkg::AICBI_HUNG;
        else if (state.fsm == aicbi_pkg::AICBI_ACK2 && bus.hold &&
                 req_in.remote_read)
          next_state.fsm = aicbi_pkg::AICBI_HUNG;
        else if (state.bus_backoff_n_1clk && bus.hold && !bus.backoff)
          next_state.fsm = aicbi_pkg::AICBI_HUNG;
        else if (state.fsm == aicbi_pkg::AICBI_ACK2 && state.stray_ready &&
                 bus.backoff)
          next_state.fsm = aicbi_pkg::AICBI_HUNG;
        else if (!bus.backoff && state.clk_cnt + 1'b1 >= limit) begin
          next_state.fsm = aicbi_pkg::AICBI_IDLE;
          if (state.fsm == aicbi_pkg::AICBI_ACK2)
            next_state.ack2_done = 1'b1;
          else
            next_state.regrd_done = 1'b1;
        end
      end
      aicbi_pkg::AICBI_HUNG: next_state.fsm = aicbi_pkg::AICBI_HUNG;
      default: next_state.fsm = aicbi_pkg::AICBI_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state          <= '0;
      state.fsm      <= aicbi_pkg::AICBI_IDLE;
      state.internal_error_n_n   <= 1'b1;
      state.in_reset <= 1'b1;
      state.unit_id  <= aicbi_pkg::ID_RESET_VALUE;
    end else begin
      state <= next_state;
    end
  end

  assign ack2_done_out             = state.ack2_done;
  assign regrd_done_out            = state.regrd_done;
  assign hung_out                  = state.fsm == aicbi_pkg::AICBI_HUNG;
  assign single_read_out           = state.single_read;
  assign bus_desync_out            = state.desync;
  assign bus_cycle_out             = state.bus_cycle;
  assign internal_error_n_out      = state.internal_error_n_n;
  assign soft_init_event_out       = state.init_ev;
  assign mgmt_event_out            = state.smi_ev;
  assign unit_id_out               = state.unit_id;
  assign outputs_tristate_out      = state.tristate;
  assign interrupt_unit_enable_out = state.unit_en;
endmodule

// >>> test/aicbi_properties.sv
// Port checker for the bus cycle interlock block
`timescale 1ns/1ps
module aicbi_properties (
  input wire logic                  clock_in,
  input wire logic                  reset_n_in,
  input wire logic                  redundancy_lockstep_in,
  input wire aicbi_pkg::aicbi_req_t req_in,
  input wire logic                  ack2_done_out,
  input wire logic                  hung_out,
  input wire logic                  internal_error_n_out,
  input wire logic                  soft_init_event_out,
  input wire logic                  mgmt_event_out,
  input wire logic [3:0]            unit_id_out
);
  // Straps land a few clocks after reset, so id checks wait
  logic [3:0] settle;
  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in) settle <= 4'h0;
    else if (settle != 4'hF) settle <= settle + 4'h1;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  property p_hung_sticky; hung_out |=> hung_out; endproperty
  a_hung_sticky: assert property (p_hung_sticky)
    else $error("hung flag dropped");
  property p_ack_pulse; ack2_done_out |=> !ack2_done_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack done longer than one clock");
  property p_ack_len;
    ack2_done_out |-> $past(req_in.ack2_start, 4) && !hung_out;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("ack done too early or while hung");
  property p_err_one;
    !internal_error_n_out |=> internal_error_n_out;
  endproperty
  a_err_one: assert property (p_err_one)
    else $error("error pulse longer than one clock");
  property p_err_mode;
    $fell(internal_error_n_out) |-> redundancy_lockstep_in;
  endproperty
  a_err_mode: assert property (p_err_mode)
    else $error("error pulse outside lockstep");
  property p_init_pulse;
    soft_init_event_out |=> !soft_init_event_out;
  endproperty
  a_init_pulse: assert property (p_init_pulse)
    else $error("soft init retriggered");
  property p_mgmt_pulse; mgmt_event_out |=> !mgmt_event_out; endproperty
  a_mgmt_pulse: assert property (p_mgmt_pulse)
    else $error("management event retriggered");
  property p_id_write;
    settle == 4'hF && $changed(unit_id_out) |->
      $past(req_in.id_write) || $past(req_in.id_write, 2);
  endproperty
  a_id_write: assert property (p_id_write)
    else $error("unit id changed without write");
endmodule

// >>> test/aicbi_chipset.sv
// Chipset model for backoff, hold, ready and serial clock pins
`timescale 1ns/1ps
module aicbi_chipset (
  input  wire logic clock_in,
  output logic      backoff_n_out,
  output logic      hold_out,
  output logic      strobe_n_out,
  output logic      ready_n_out,
  output logic      serial_clk_out
);
  // Strobe starts high: bus idle, ready never meets strobe
  initial begin
    backoff_n_out = 1'b1;
    hold_out = 1'b0;
    strobe_n_out = 1'b1;
    ready_n_out = 1'b1;
    serial_clk_out = 1'b0;
  end
  // Free running, so a long reset sees twenty toggles
  always #62.5 serial_clk_out = ~serial_clk_out;
  // Caller sets length; one clock only off linefills
  task automatic backoff(input int n);
    backoff_n_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    backoff_n_out <= 1'b1;
  endtask
  // No address hold driven: backoff length alone keeps the window
  task automatic strobe(input int n);
    strobe_n_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    strobe_n_out <= 1'b1;
  endtask
  task automatic hold(input int n);
    hold_out <= 1'b1;
    repeat (n) @(posedge clock_in);
    hold_out <= 1'b0;
  endtask
  task automatic ready();
    ready_n_out <= 1'b0;
    @(posedge clock_in);
    ready_n_out <= 1'b1;
  endtask
endmodule

// >>> test/aicbi_tb_top.sv
// Self-checking bench for the bus cycle interlock block
`timescale 1ns/1ps
module aicbi_tb_top;
  logic clock_in, reset_n_in, bus_backoff_n_in, bus_hold_in, soft_init_in;
  logic address_strobe_n_in, burst_ready_n_in, redundancy_lockstep_in;
  logic system_mgmt_interrupt_n_in, interrupt_serial_clock_in, hung_out;
  logic redundancy_master_checker_n_in, ack2_done_out, regrd_done_out;
  logic single_read_out, bus_desync_out, bus_cycle_out, mgmt_event_out;
  logic internal_error_n_out, soft_init_event_out, outputs_tristate_out;
  logic interrupt_unit_enable_out;
  logic [3:0] byte_enables_n_in, unit_id_out;
  aicbi_pkg::aicbi_req_t req_in;
  int err_total, checked, cyc, n0, n1, ev_si, ev_mg;
  int extra = aicbi_pkg::ACK_CLOCKS_REMOTE - aicbi_pkg::ACK_CLOCKS_PLAIN;

  aicbi_top u_aicbi_top (.clock_in, .reset_n_in, .bus_backoff_n_in,
    .bus_hold_in, .address_strobe_n_in, .burst_ready_n_in, .soft_init_in,
    .system_mgmt_interrupt_n_in, .interrupt_serial_clock_in,
    .byte_enables_n_in, .redundancy_master_checker_n_in,
    .redundancy_lockstep_in, .req_in, .ack2_done_out, .regrd_done_out,
    .hung_out, .single_read_out, .bus_desync_out, .bus_cycle_out,
    .internal_error_n_out, .soft_init_event_out, .mgmt_event_out,
    .unit_id_out, .outputs_tristate_out, .interrupt_unit_enable_out);
  aicbi_chipset u_aicbi_chipset (.clock_in,
    .backoff_n_out(bus_backoff_n_in), .hold_out(bus_hold_in),
    .strobe_n_out(address_strobe_n_in), .ready_n_out(burst_ready_n_in),
    .serial_clk_out(interrupt_serial_clock_in));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // Run needs about 2400 clocks
  always @(posedge clock_in) begin
    ev_si += int'(soft_init_event_out === 1'b1);
    ev_mg += int'(mgmt_event_out === 1'b1);
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(input int n);
    reset_n_in <= 1'b0;
    repeat (n) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (8) @(posedge clock_in);
  endtask
  // Request held until done; 40 means it never came
  task automatic run_cyc(input logic rd, rem, output int n);
    req_in.regrd_start <= rd;
    req_in.ack2_start <= !rd;
    req_in.remote_read <= rem;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while ((rd ? regrd_done_out : ack2_done_out) !== 1'b1 && n < 40);
    req_in.regrd_start <= 1'b0;
    req_in.ack2_start <= 1'b0;
    req_in.remote_read <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  task automatic send_msg(input logic mg);
    req_in.msg_init <= !mg;
    req_in.msg_smi <= mg;
    @(posedge clock_in);
    req_in.msg_init <= 1'b0;
    req_in.msg_smi <= 1'b0;
    repeat (6) @(posedge clock_in);
  endtask
  task automatic pin_test(input logic mg);
    n0 = mg ? ev_mg : ev_si;
    system_mgmt_interrupt_n_in <= !mg;
    soft_init_in <= !mg;
    repeat (8) @(posedge clock_in);
    send_msg(mg);
    check("held pin", 8'((mg ? ev_mg : ev_si) - n0), 1);
    system_mgmt_interrupt_n_in <= 1'b1;
    soft_init_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    send_msg(mg);
    check("message", 8'((mg ? ev_mg : ev_si) - n0), 2);
  endtask

  initial begin
    reset_n_in = 1'b0;
    soft_init_in = 1'b0;
    system_mgmt_interrupt_n_in = 1'b1;
    byte_enables_n_in = 4'h1;
    redundancy_master_checker_n_in = 1'b0;
    redundancy_lockstep_in = 1'b0;
    req_in = '0;
    do_reset(6);
    // Toggle tally is unknown until a first release has been seen
    do_reset(6);
    check("enable", interrupt_unit_enable_out, 1'b0);
    check("tristate", outputs_tristate_out, 1'b1);
    run_cyc(1'b0, 1'b0, n0);
    check("refused ack", 8'(n0), 40);
    redundancy_master_checker_n_in <= 1'b1;
    do_reset(500);
    redundancy_master_checker_n_in <= 1'b0;
    @(posedge clock_in);
    check("tristate", outputs_tristate_out, 1'b0);
    check("enable", interrupt_unit_enable_out, 1'b1);
    check("strap id", unit_id_out, 4'h1);
    req_in.id_value <= 4'hA;
    req_in.id_write <= 1'b1;
    @(posedge clock_in);
    req_in.id_write <= 1'b0;
    repeat (2) @(posedge clock_in);
    check("written id", unit_id_out, 4'hA);
    run_cyc(1'b0, 1'b0, n0);
    run_cyc(1'b0, 1'b1, n1);
    check("remote ack", 8'(n1 - n0), 8'(extra));
    fork u_aicbi_chipset.strobe(8); join_none
    repeat (4) @(posedge clock_in);
    check("bus cycle", bus_cycle_out, 1'b1);
    run_cyc(1'b0, 1'b0, n0);
    check("busy bus", {6'h00, n0 > aicbi_pkg::ACK_CLOCKS_PLAIN + 2,
          n0 < 40}, 8'h03);
    fork u_aicbi_chipset.backoff(12); join_none
    run_cyc(1'b0, 1'b0, n0);
    check("long backoff", {6'h00, hung_out, n0 < 40}, 8'h01);
    fork u_aicbi_chipset.backoff(1); join_none
    run_cyc(1'b0, 1'b0, n0);
    check("short backoff", {6'h00, hung_out, n0 < 40}, 8'h02);
    byte_enables_n_in <= 4'h0;
    redundancy_master_checker_n_in <= 1'b1;
    do_reset(500);
    check("default id", unit_id_out, 4'h0);
    fork u_aicbi_chipset.hold(3); join_none
    run_cyc(1'b0, 1'b1, n0);
    check("hold remote", hung_out, 1'b1);
    do_reset(500);
    fork u_aicbi_chipset.backoff(1); u_aicbi_chipset.hold(1); join_none
    run_cyc(1'b1, 1'b0, n0);
    check("joint pulse", {6'h00, hung_out, n0 < 40}, 8'h01);
    fork begin
      u_aicbi_chipset.backoff(1);
      u_aicbi_chipset.hold(1);
    end join_none
    run_cyc(1'b1, 1'b0, n0);
    check("split pulse", hung_out, 1'b1);
    do_reset(500);
    pin_test(1'b0);
    pin_test(1'b1);
    redundancy_lockstep_in <= 1'b1;
    req_in.reg_write <= 1'b1;
    req_in.pipelined <= 1'b1;
    repeat (2) @(posedge clock_in);
    u_aicbi_chipset.ready();
    n0 = 0;
    repeat (12) begin
      @(posedge clock_in);
      n0 += int'(internal_error_n_out === 1'b0);
    end
    check("error pulse", 8'(n0), 1);
    check("write off bus", bus_cycle_out, 1'b0);
    stop_test();
  end
endmodule

bind aicbi_top aicbi_properties u_aicbi_properties (.clock_in, .reset_n_in,
  .redundancy_lockstep_in, .req_in, .ack2_done_out, .hung_out,
  .internal_error_n_out, .soft_init_event_out, .mgmt_event_out,
  .unit_id_out);
